// ==== tx_descriptor_dma.sv ====
// Transmit descriptor DMA with AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// R1 - Odd start reads aligned word, drops lead bytes.
// R2 - Fragments hold one byte or more, any alignment.
// R3 - Software sets descriptors and address before go.
// R4 - Upper address register gives high address bits.
// R5 - Chained descriptors; only the last ends the list.
// R6 - Filter miss sets monitored bad in status.
// R7 - Go loads control, sizes, count and pointer.
// R8 - Link loads current address after success, not on halt.
// R9 - Later fragments fetch pointer and length.
// R10 - End writes status, reads link; list end stops.
// R11 - Collision restores saved pointer; fifteen retries.
// R12 - Bursts of six, three per fragment, then two.
// R13 - Underrun, mismatch, collisions, deferral abort.
// R14 - Halt acts after the status write.
// R15 - Append with end of list set, then go again.
// R16 - Go while active ignored; later go resumes.
// R17 - Sixty-four register slots, six select bits.
// R18 - Software avoids test and internal registers.
// R19 - Fields are sixteen bits, low half of word.
// R20 - Config bits fifteen to twelve go to control.
// R21 - Link bits fifteen to one address, bit zero end.
// R22 - Status holds control status and collision count.
module tx_descriptor_dma (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    output var tx_dma_pkg::mem_req_type o_mem,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    output var tx_dma_pkg::tx_byte_type o_tx,
    input wire logic i_tx_ready,
    input wire tx_dma_pkg::mac_event_type i_mac
);
    import tx_dma_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] desc_addr(input logic [15:0] upper,
        input logic [15:0] cur, input logic w32, input logic [15:0] fnum);
        logic [31:0] base;
        base = {upper, cur[15:1], 1'b0};
        return base + (w32 ? {14'h0000, fnum, 2'b00} : {15'h0000, fnum, 1'b0});
    endfunction

    function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] i);
        logic [31:0] t;
        t = w >> {i, 3'b000};
        return t[7:0];
    endfunction

    dma_state_type s;
    dma_state_type next_s;
    logic [31:0] step;
    logic [31:0] aligned;
    logic [1:0] lead;
    logic [1:0] last_lane;
    logic last_frag;
    logic quiet;
    logic packet_state;
    logic ev_coll;
    logic ev_abort;
    logic addr_phase;
    logic [15:0] field;
    logic [15:0] status_word;

    assign step = s.w32 ? 32'h00000004 : 32'h00000002;
    assign aligned = s.w32 ? {s.cursor[31:2], 2'b00} : {s.cursor[31:1], 1'b0}; // R1
    assign lead = s.w32 ? s.cursor[1:0] : {1'b0, s.cursor[0]}; // R1
    assign last_lane = s.w32 ? 2'h3 : 2'h1;
    assign last_frag = (s.fidx + 16'h0001) >= s.fcount;
    assign quiet = ~s.mem.req | i_mem_ack;
    assign packet_state = (s.state == ST_DESC) | (s.state == ST_FRAG) |
        (s.state == ST_DRD) | (s.state == ST_DOUT);
    assign ev_coll = s.coll_pend | i_mac.collision;
    assign ev_abort = s.abort_pend | i_mac.underrun | i_mac.count_mismatch |
        i_mac.excess_coll | (i_mac.excess_defer & ~s.tx_control_reg[TCR_DEFER_DIS_BIT]) |
        (i_mac.collision & (s.ncoll == MAX_RETRIES)); // R13
    assign addr_phase = i_hsel & i_hready & i_htrans[1];
    assign field = i_mem_rdata[15:0]; // R19
    assign status_word = {s.ncoll, s.tx_control_reg[10:0]}; // R22

    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = s.hrdata;
    assign o_mem = s.mem;
    assign o_tx = s.tx;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        // Register read, address phase
        next_s.wr_pend = addr_phase & i_hwrite & (i_hsize == AHB_SIZE_WORD);
        next_s.wr_idx = i_haddr[7:2]; // R17
        if (addr_phase & ~i_hwrite) begin
            next_s.hrdata = 32'h00000000;
            if (i_haddr[31:8] == 24'h000000) begin
                case (i_haddr[7:2]) // R17
                    REG_COMMAND: next_s.hrdata[1:0] = {s.halt, s.go};
                    REG_TX_CONTROL: next_s.hrdata[15:0] = s.tx_control_reg;
                    REG_INT_STATUS: next_s.hrdata[1:0] = s.interrupt_status_reg;
                    REG_DATA_CONFIG: next_s.hrdata[0] = s.w32;
                    REG_UPPER_TDA: next_s.hrdata[15:0] = s.upper;
                    REG_CURRENT_TDA: next_s.hrdata[15:0] = s.cur;
                    REG_PACKET_SIZE: next_s.hrdata[15:0] = s.psize;
                    REG_FRAG_COUNT: next_s.hrdata[15:0] = s.fcount;
                    REG_FRAG_PTR_LO: next_s.hrdata[15:0] = s.fptr[15:0];
                    REG_FRAG_PTR_HI: next_s.hrdata[15:0] = s.fptr[31:16];
                    REG_FRAG_SIZE: next_s.hrdata[15:0] = s.fsize;
                    REG_SAVED_TDA: next_s.hrdata[15:0] = s.saved;
                    REG_COLLISIONS: next_s.hrdata[4:0] = s.ncoll;
                    default: next_s.hrdata = 32'h00000000;
                endcase
            end
        end
        // Register write, data phase
        if (s.wr_pend) begin
            case (s.wr_idx)
                REG_COMMAND: begin
                    if (i_hwdata[CMD_GO_BIT] && s.state == ST_IDLE) begin // R16
                        next_s.go = 1'b1;
                        next_s.ncoll = 5'h00;
                        next_s.fidx = 16'h0000;
                        next_s.saved = s.cur; // R11
                        if (s.resume) begin
                            next_s.state = ST_LINK; // R15 R16
                        end else begin
                            next_s.state = ST_DESC; // R3 R7
                            next_s.fnum = FIELD_CONFIG;
                            next_s.bcnt = 3'h0;
                        end
                    end
                    if (i_hwdata[CMD_HALT_BIT] && s.state != ST_IDLE) begin
                        next_s.halt = 1'b1;
                    end
                end
                REG_INT_STATUS: next_s.interrupt_status_reg = s.interrupt_status_reg & ~i_hwdata[1:0];
                REG_DATA_CONFIG: begin
                    if (s.state == ST_IDLE) begin
                        next_s.w32 = i_hwdata[0];
                    end
                end
                REG_UPPER_TDA: begin
                    if (s.state == ST_IDLE) begin
                        next_s.upper = i_hwdata[15:0]; // R4
                    end
                end
                REG_CURRENT_TDA: begin
                    if (s.state == ST_IDLE) begin
                        next_s.cur = i_hwdata[15:0];
                        next_s.saved = i_hwdata[15:0];
                        next_s.resume = 1'b0;
                    end
                end
                default: next_s.wr_pend = next_s.wr_pend;
            endcase
        end
        // Memory request issue
        if (!s.mem.req && s.state != ST_IDLE && s.state != ST_DOUT) begin
            next_s.mem.req = 1'b1;
            next_s.mem.we = (s.state == ST_STAT);
            next_s.mem.wdata = {16'h0000, status_word};
            if (s.state == ST_DRD) begin
                next_s.mem.addr = aligned; // R1
            end else if (s.state == ST_STAT) begin
                next_s.mem.addr = desc_addr(s.upper, s.cur, s.w32, FIELD_STATUS);
            end else begin
                next_s.mem.addr = desc_addr(s.upper, s.cur, s.w32, s.fnum); // R4
            end
        end
        if (s.mem.req && i_mem_ack) begin
            next_s.mem.req = 1'b0;
            next_s.mem.we = 1'b0;
        end
        // Engine
        case (s.state)
            ST_IDLE: next_s.tx.valid = 1'b0;
            ST_DESC, ST_FRAG: begin
                if (s.mem.req && i_mem_ack) begin
                    case (s.bcnt) // R7
                        3'h0: next_s.tx_control_reg[TCR_CFG_MSB:TCR_CFG_LSB] =
                            field[TCR_CFG_MSB:TCR_CFG_LSB]; // R20
                        3'h1: next_s.psize = field;
                        3'h2: next_s.fcount = field;
                        3'h3: next_s.fptr[15:0] = field;
                        3'h4: next_s.fptr[31:16] = field;
                        default: next_s.fsize = field;
                    endcase
                    next_s.fnum = s.fnum + 16'h0001;
                    next_s.bcnt = s.bcnt + 3'h1;
                    if (s.bcnt == DESC_BURST_LAST) begin // R12
                        next_s.state = ST_DRD;
                        next_s.cursor = s.fptr;
                        next_s.remaining = field;
                    end
                end
            end
            ST_DRD: begin
                if (s.mem.req && i_mem_ack) begin
                    next_s.word = i_mem_rdata;
                    next_s.bidx = lead; // R1
                    next_s.cursor = aligned + step;
                    next_s.state = ST_DOUT;
                    next_s.tx.valid = 1'b1;
                    next_s.tx.data = pick_byte(i_mem_rdata, lead);
                    next_s.tx.last = (s.remaining == 16'h0001) & last_frag;
                end
            end
            ST_DOUT: begin
                if (i_tx_ready) begin
                    next_s.remaining = s.remaining - 16'h0001;
                    if (s.remaining == 16'h0001) begin
                        next_s.tx.valid = 1'b0;
                        next_s.tx.last = 1'b0;
                        next_s.fidx = s.fidx + 16'h0001;
                        if (!last_frag) begin
                            next_s.state = ST_FRAG; // R9 R12
                            next_s.bcnt = FRAG_BURST_FIRST;
                        end else begin
                            next_s.state = ST_STAT; // R10
                            next_s.tx_control_reg[10:0] = i_mac.status;
                            next_s.tx_control_reg[STAT_PMB_BIT] = ~i_mac.sa_match; // R6
                        end
                    end else if (s.bidx == last_lane) begin
                        next_s.tx.valid = 1'b0;
                        next_s.state = ST_DRD;
                    end else begin
                        next_s.bidx = s.bidx + 2'h1;
                        next_s.tx.data = pick_byte(s.word, s.bidx + 2'h1);
                        next_s.tx.last = (s.remaining == 16'h0002) & last_frag;
                    end
                end
            end
            ST_STAT: begin
                if (s.mem.req && i_mem_ack) begin
                    if (s.halt) begin
                        next_s.state = ST_IDLE; // R14 R8
                        next_s.go = 1'b0;
                        next_s.halt = 1'b0;
                    end else begin
                        next_s.state = ST_LINK; // R10 R12
                    end
                end
            end
            ST_LINK: begin
                if (s.mem.req && i_mem_ack) begin
                    if (field[0]) begin // R21 R5
                        next_s.state = ST_IDLE; // R10
                        next_s.interrupt_status_reg[ISR_DONE_BIT] = 1'b1;
                        next_s.go = 1'b0;
                        next_s.halt = 1'b0;
                        next_s.resume = 1'b1; // R16
                    end else begin
                        next_s.cur = {field[15:1], 1'b0}; // R8 R21
                        next_s.saved = {field[15:1], 1'b0}; // R11
                        next_s.resume = 1'b0;
                        next_s.ncoll = 5'h00;
                        next_s.fidx = 16'h0000;
                        next_s.fnum = FIELD_CONFIG;
                        next_s.bcnt = 3'h0;
                        next_s.state = ST_DESC;
                    end
                end
            end
            default: next_s.state = ST_IDLE;
        endcase
        // Collision and abort events, applied once no fetch is open
        if (packet_state) begin
            if (ev_abort && quiet) begin
                next_s.state = ST_IDLE; // R13
                next_s.go = 1'b0;
                next_s.halt = 1'b0;
                next_s.resume = 1'b0;
                next_s.interrupt_status_reg[ISR_ABORT_BIT] = 1'b1;
                next_s.tx.valid = 1'b0;
                next_s.tx.last = 1'b0;
                next_s.mem.req = 1'b0;
                next_s.abort_pend = 1'b0;
                next_s.coll_pend = 1'b0;
            end else if (ev_coll && quiet) begin
                next_s.ncoll = s.ncoll + 5'h01; // R11
                next_s.cur = s.saved; // R11
                next_s.state = ST_DESC;
                next_s.fnum = FIELD_CONFIG;
                next_s.bcnt = 3'h0;
                next_s.fidx = 16'h0000;
                next_s.tx.valid = 1'b0;
                next_s.tx.last = 1'b0;
                next_s.mem.req = 1'b0;
                next_s.coll_pend = 1'b0;
            end else begin
                next_s.abort_pend = ev_abort;
                next_s.coll_pend = ev_coll;
            end
        end else begin
            next_s.abort_pend = 1'b0;
            next_s.coll_pend = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s <= DMA_RESET;
        end else begin
            s <= next_s;
        end
    end
endmodule // tx_descriptor_dma

`default_nettype wire

// ==== tx_descriptor_dma_asserts.sv ====
// Port checker for the transmit descriptor DMA
`timescale 1ns/1ns
`default_nettype none
module tx_descriptor_dma_asserts (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic [31:0] o_hrdata,
    input wire tx_dma_pkg::mem_req_type o_mem,
    input wire logic i_mem_ack,
    input wire tx_dma_pkg::tx_byte_type o_tx,
    input wire logic i_tx_ready,
    input wire tx_dma_pkg::mac_event_type i_mac
);
    import tx_dma_pkg::*;
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic rd_taken;
    assign rd_taken = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
    sequence mem_wait; o_mem.req && !i_mem_ack; endsequence
    sequence mem_done; o_mem.req && i_mem_ack; endsequence
    a_bus_okay: assert property (o_hreadyout && !o_hresp)
        else $error("bus answer bad");
    a_unmapped_zero: assert property (rd_taken && i_haddr[7:2] > REG_COLLISIONS |=> o_hrdata == 0)
        else $error("unmapped read");
    a_rdata_stands: assert property (!rd_taken |=> $stable(o_hrdata))
        else $error("read data moved");
    a_req_held: assert property (mem_wait |=> o_mem.req && $stable(o_mem.addr) && $stable(o_mem.wdata))
        else $error("request moved");
    a_req_gap: assert property (mem_done |=> !o_mem.req)
        else $error("request held");
    a_tx_held: assert property (o_tx.valid && !i_tx_ready && i_mac[16:12] == 5'h00 |=> o_tx.valid && $stable(o_tx.data))
        else $error("byte moved");
    a_tx_after_word: assert property ($rose(o_tx.valid) |-> $past(i_mem_ack) && !$past(o_mem.we))
        else $error("byte without read");
    a_even_addr: assert property (o_mem.req |-> !o_mem.addr[0])
        else $error("odd access");
    a_coll_bound: assert property (o_mem.req && o_mem.we |-> o_mem.wdata[15:11] <= MAX_RETRIES)
        else $error("too many collisions");
endmodule // tx_descriptor_dma_asserts
bind tx_descriptor_dma tx_descriptor_dma_asserts tx_descriptor_dma_asserts_inst (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata), .o_mem(o_mem),
    .i_mem_ack(i_mem_ack), .o_tx(o_tx), .i_tx_ready(i_tx_ready), .i_mac(i_mac));
`default_nettype wire

// ==== tx_descriptor_dma_test.sv ====
// Self-checking bench for the transmit descriptor DMA
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end
module tx_descriptor_dma_test;
    import tx_dma_pkg::*;
    logic i_clk, hready, hresp, mem_ack;
    logic i_rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, hold = 1'b0, tx_ready = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] mem_delay = 3'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, mem_rdata, r;
    mem_req_type mem;
    tx_byte_type tx;
    mac_event_type mac = '{status: 11'h005, default: '0};
    int n_errors = 0, samples_checked = 0, n_last = 0;
    logic [7:0] txq [$];
    tx_descriptor_dma tx_descriptor_dma_inst (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(AHB_SIZE_WORD), .i_hwdata(hwdata),
        .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
        .o_mem(mem), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_tx(tx),
        .i_tx_ready(tx_ready), .i_mac(mac));
    tx_mem_model tx_mem_model_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_mem(mem),
        .i_delay(mem_delay), .o_ack(mem_ack), .o_rdata(mem_rdata));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Transmit path sink, stalling every other cycle, and on every cycle while hold is set
    always @(posedge i_clk) begin
        if (tx.valid === 1'b1 && tx_ready === 1'b1) begin
            txq.push_back(tx.data);
            n_last += int'(tx.last);
        end
        tx_ready <= !hold && !tx_ready;
    end
    // ----------------------------------------------------------------
    // Bus and helper tasks
    // ----------------------------------------------------------------
    task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] wd = 32'h0);
        @(posedge i_clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge i_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge i_clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic desc(input int b, input logic [15:0] cfg, ps, nf, p0, s0, p1, s1, lk);
        logic [15:0] f [0:10];
        f = '{16'h0, cfg, ps, nf, p0, 16'h0, s0, p1, 16'h0, s1, lk};
        if (nf == 16'h1)
            f[7] = lk;
        for (int i = 0; i < 11; i++)
            tx_mem_model_inst.mem[b / 4 + i] = {16'hBEEF, f[i]};
    endtask
    function automatic logic [15:0] stat(input int b);
        return tx_mem_model_inst.mem[b / 4][15:0];
    endfunction
    task automatic wait_idle;
        r = 32'h1;
        for (int i = 0; i < 3000 && r[0] !== 1'b0; i++)
            bus(1'b0, REG_COMMAND);
        `CHECK(r[0], 1'b0)
    endtask
    task automatic wait_tx(input logic lvl);
        for (int i = 0; i < 5000 && tx.valid !== lvl; i++)
            @(posedge i_clk);
    endtask
    task automatic start(input logic [31:0] cur);
        bus(1'b1, REG_INT_STATUS, 32'h3);
        bus(1'b1, REG_CURRENT_TDA, cur);
        hold = 1'b1;
        txq.delete();
        bus(1'b1, REG_COMMAND, 32'h1);
    endtask
    task automatic pulse(input int k);
        wait_tx(1'b1);
        mac[k] <= 1'b1;
        @(posedge i_clk);
        mac[k] <= 1'b0;
        wait_tx(1'b0);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic regs_test;
        bus(1'b1, 6'h3F, 32'hFFFFFFFF);
        bus(1'b0, 6'h3F);
        `CHECK(r, 32'h0)
        bus(1'b1, REG_DATA_CONFIG, 32'h1);
        bus(1'b1, REG_UPPER_TDA, 32'h0);
        bus(1'b1, REG_CURRENT_TDA, 32'h40);
        bus(1'b0, REG_SAVED_TDA);
        `CHECK(r, 32'h40)
    endtask
    task automatic chain_test;
        logic [7:0] exp [0:7] = '{8'h22, 8'h33, 8'h44, 8'h88, 8'hAA, 8'hBB, 8'hCC, 8'hDD};
        int acc;
        acc = tx_mem_model_inst.n_access;
        bus(1'b1, REG_COMMAND, 32'h1);
        repeat (20) @(posedge i_clk);
        bus(1'b1, REG_COMMAND, 32'h1);
        wait_idle();
        `CHECK(txq.size(), 8)
        for (int i = 0; i < 8; i++) `CHECK(txq[i], exp[i])
        `CHECK(n_last, 2)
        `CHECK(tx_mem_model_inst.n_access - acc, 22)
        `CHECK(stat(32'h40), 16'h000D)
        `CHECK(stat(32'h80), 16'h000D)
        bus(1'b0, REG_CURRENT_TDA);
        `CHECK(r, 32'h80)
        bus(1'b0, REG_TX_CONTROL);
        `CHECK(r[15:12], 4'h2)
        bus(1'b0, REG_INT_STATUS);
        `CHECK(r[0], 1'b1)
    endtask
    task automatic append_test;
        txq.delete();
        tx_mem_model_inst.mem[32'h80 / 4 + 10] = {16'hBEEF, 16'h00C0};
        bus(1'b1, REG_INT_STATUS, 32'h1);
        bus(1'b1, REG_COMMAND, 32'h1);
        wait_idle();
        `CHECK(txq.size(), 1)
        `CHECK(txq[0], 8'hEE)
        bus(1'b0, REG_CURRENT_TDA);
        `CHECK(r, 32'hC0)
    endtask
    task automatic halt_test;
        tx_mem_model_inst.mem[16] = 32'h0;
        start(32'h40);
        wait_tx(1'b1);
        bus(1'b1, REG_COMMAND, 32'h2);
        hold = 1'b0;
        wait_idle();
        `CHECK(txq.size(), 3)
        `CHECK(stat(32'h40), 16'h000D)
        bus(1'b0, REG_CURRENT_TDA);
        `CHECK(r, 32'h40)
    endtask
    task automatic abort_test;
        for (int k = 12; k < 16; k++) begin
            start(32'hC0);
            pulse(k);
            wait_idle();
            bus(1'b0, REG_INT_STATUS);
            `CHECK(r[1:0], 2'b10)
            bus(1'b0, REG_CURRENT_TDA);
            `CHECK(r, 32'hC0)
        end
    endtask
    task automatic coll_test;
        start(32'hC0);
        pulse(16);
        hold = 1'b0;
        wait_idle();
        bus(1'b0, REG_COLLISIONS);
        `CHECK(r[4:0], 5'h01)
        `CHECK(stat(32'hC0), 16'h080D)
        start(32'hC0);
        repeat (16) pulse(16);
        hold = 1'b0;
        wait_idle();
        bus(1'b0, REG_INT_STATUS);
        `CHECK(r[1:0], 2'b10)
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #500000;
        n_errors++;
        conclude();
    end
    initial begin
        desc(32'h40, 16'hF5A5, 16'h3, 16'h1, 16'h0101, 16'h3, 16'h0, 16'h0, 16'h0080);
        desc(32'h80, 16'h2000, 16'h5, 16'h2, 16'h0203, 16'h1, 16'h0300, 16'h4, 16'h00C1);
        desc(32'hC0, 16'h0000, 16'h1, 16'h1, 16'h03F0, 16'h1, 16'h0, 16'h0, 16'h00F1);
        tx_mem_model_inst.mem[64] = 32'h44332211;
        tx_mem_model_inst.mem[128] = 32'h88776655;
        tx_mem_model_inst.mem[192] = 32'hDDCCBBAA;
        tx_mem_model_inst.mem[252] = 32'h000000EE;
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        regs_test();
        chain_test();
        append_test();
        mem_delay <= 3'h2;
        halt_test();
        abort_test();
        coll_test();
        conclude();
    end
endmodule // tx_descriptor_dma_test
`default_nettype wire

// ==== tx_dma_pkg.sv ====
// Constants and types shared by the transmit descriptor DMA
package tx_dma_pkg;
    // ----------------------------------------------------------------
    // Register indices (byte address is index times four)
    // ----------------------------------------------------------------
    localparam logic [5:0] REG_COMMAND = 6'h00;
    localparam logic [5:0] REG_TX_CONTROL = 6'h01;
    localparam logic [5:0] REG_INT_STATUS = 6'h02;
    localparam logic [5:0] REG_DATA_CONFIG = 6'h03;
    localparam logic [5:0] REG_UPPER_TDA = 6'h04;
    localparam logic [5:0] REG_CURRENT_TDA = 6'h05;
    localparam logic [5:0] REG_PACKET_SIZE = 6'h06;
    localparam logic [5:0] REG_FRAG_COUNT = 6'h07;
    localparam logic [5:0] REG_FRAG_PTR_LO = 6'h08;
    localparam logic [5:0] REG_FRAG_PTR_HI = 6'h09;
    localparam logic [5:0] REG_FRAG_SIZE = 6'h0A;
    localparam logic [5:0] REG_SAVED_TDA = 6'h0B;
    localparam logic [5:0] REG_COLLISIONS = 6'h0C;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CMD_GO_BIT = 0;
    localparam int CMD_HALT_BIT = 1;
    localparam int ISR_DONE_BIT = 0;
    localparam int ISR_ABORT_BIT = 1;
    localparam int TCR_CFG_MSB = 15;
    localparam int TCR_CFG_LSB = 12;
    localparam int TCR_DEFER_DIS_BIT = 12;
    localparam int STAT_PMB_BIT = 3;
    localparam logic [15:0] FIELD_STATUS = 16'h0000;
    localparam logic [15:0] FIELD_CONFIG = 16'h0001;
    localparam logic [2:0] DESC_BURST_LAST = 3'h5;
    localparam logic [2:0] FRAG_BURST_FIRST = 3'h3;
    localparam logic [4:0] MAX_RETRIES = 5'h0F;
    localparam logic [2:0] AHB_SIZE_WORD = 3'h2;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_DESC = 7'h02,
        ST_FRAG = 7'h04,
        ST_DRD = 7'h08,
        ST_DOUT = 7'h10,
        ST_STAT = 7'h20,
        ST_LINK = 7'h40
    } state_type;
    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_type;
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } tx_byte_type;
    typedef struct packed {
        logic collision;
        logic underrun;
        logic count_mismatch;
        logic excess_coll;
        logic excess_defer;
        logic sa_match;
        logic [10:0] status;
    } mac_event_type;
    typedef struct packed {
        state_type state;
        logic go;
        logic halt;
        logic resume;
        logic [1:0] interrupt_status_reg;
        logic w32;
        logic coll_pend;
        logic abort_pend;
        logic [15:0] upper;
        logic [15:0] cur;
        logic [15:0] saved;
        logic [15:0] tx_control_reg;
        logic [15:0] psize;
        logic [15:0] fcount;
        logic [15:0] fsize;
        logic [15:0] fidx;
        logic [15:0] fnum;
        logic [15:0] remaining;
        logic [31:0] fptr;
        logic [31:0] cursor;
        logic [31:0] word;
        logic [31:0] hrdata;
        logic [4:0] ncoll;
        logic [2:0] bcnt;
        logic [1:0] bidx;
        mem_req_type mem;
        tx_byte_type tx;
        logic wr_pend;
        logic [5:0] wr_idx;
    } dma_state_type;
    localparam dma_state_type DMA_RESET = '{state: ST_IDLE, default: '0};
endpackage

// ==== tx_mem_model.sv ====
// System memory model answering the DMA request port
`timescale 1ns/1ns
`default_nettype none
module tx_mem_model (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire tx_dma_pkg::mem_req_type i_mem,
    input wire logic [2:0] i_delay,
    output logic o_ack,
    output logic [31:0] o_rdata
);
    logic [31:0] mem [0:255];
    logic [2:0] wait_cnt;
    int n_access = 0;
    // Answer after i_delay waiting cycles
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ack <= 1'b0;
            o_rdata <= 32'h5A5A5A5A;
            wait_cnt <= 3'h0;
        end else begin
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
            if (i_mem.req && !o_ack) begin
                if (wait_cnt >= i_delay) begin
                    o_ack <= 1'b1;
                    wait_cnt <= 3'h0;
                    n_access <= n_access + 1;
                    if (i_mem.we)
                        mem[i_mem.addr[9:2]] <= i_mem.wdata;
                    else
                        o_rdata <= mem[i_mem.addr[9:2]];
                end else begin
                    wait_cnt <= wait_cnt + 3'h1;
                end
            end
        end
    end
endmodule // tx_mem_model
`default_nettype wire
